// >>> shared/drive_io_pkg.sv
// Constants and carrier types for the drive multi-function I/O block
package drive_io_pkg;

	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TENTH_S_CYCLES = CLK_HZ / 10;
	localparam int unsigned HUNDREDTH_S_CYCLES = CLK_HZ / 100;

	localparam int unsigned N_IN = 6;
	localparam int unsigned N_RELAY = 3;

	localparam logic [7:0] SEL_UP = 8'h08;
	localparam logic [7:0] SEL_DOWN = 8'h09;
	localparam logic [7:0] SEL_TIMER_IN = 8'h23;
	localparam logic [7:0] SEL_TIMER_OUT = 8'h1B;

	// Delay settings in 0.1 s units, 6000.0 s ceiling
	localparam logic [15:0] TIMER_DELAY_MAX = 16'hEA60;
	// Step width in 0.01 Hz units, 5.00 Hz ceiling
	localparam logic [15:0] STEP_WIDTH_MAX = 16'h01F4;
	// Torque threshold in percent, 150 % ceiling
	localparam logic [7:0] TORQUE_LEVEL_MAX = 8'h96;
	// Braking delay in 0.01 s units, 65.00 s ceiling
	localparam logic [15:0] BRAKE_DELAY_MAX = 16'h1964;
	// Long press boundary: 2 s in 0.1 s units
	localparam logic [15:0] LONG_PRESS_TENTHS = 16'h0014;
	localparam logic [1:0] HOLD_REFRESH = 2'h3;

	typedef logic [N_IN-1:0][7:0] in_sel_t;
	typedef logic [N_RELAY-1:0][7:0] relay_sel_t;

	typedef struct packed {
		logic [15:0] on_delay;
		logic [15:0] off_delay;
	} timer_cfg_s;

	typedef struct packed {
		logic [15:0] step_width;
		logic ramp_set;
		logic [15:0] accel1;
		logic [15:0] decel1;
		logic [15:0] accel2;
		logic [15:0] decel2;
		logic [15:0] upper_limit;
		logic [1:0] hold_mode;
	} updown_cfg_s;

	typedef struct packed {
		logic [15:0] freq_level;
		logic [7:0] torque_level;
		logic [15:0] delay;
	} brake_cfg_s;

	typedef struct packed {
		logic running;
		logic [15:0] out_freq;
		logic [15:0] run_freq;
		logic [7:0] torque;
	} drive_state_s;

endpackage : drive_io_pkg

// >>> hdl/hold_timer.sv
// Counts how long a condition has held, in ticks of a fixed length
`timescale 1ns/1ps
`default_nettype none
module hold_timer
	import drive_io_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TENTH_S_CYCLES
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [15:0] limit,
	output logic done
);

	localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

	logic [PW-1:0] pre_q, pre_d;
	logic [15:0] cnt_q, cnt_d;

	// Dropping run restarts the count from zero
	always_comb
	begin
		pre_d = '0;
		cnt_d = '0;
		if (run && cnt_q < limit)
		begin
			pre_d = pre_q + PW'(1);
			cnt_d = cnt_q;
			if (pre_q == PRE_LAST)
			begin
				pre_d = '0;
				cnt_d = cnt_q + 16'h0001;
			end
		end
		else if (run)
		begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pre_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end

	assign done = run && (cnt_q >= limit);

endmodule : hold_timer
`default_nettype wire

// >>> hdl/drive_io.sv
// Timer relay, up/down frequency reference and brake release logic
// Contract
// RULE1 - Timer needs input code 35 and relay code 27
// RULE2 - Output on after input held for on-delay
// RULE3 - Output off after input low for off-delay
// RULE4 - Input change cancels running delay, output unchanged
// RULE5 - Input code 8 raises, code 9 lowers
// RULE6 - Step width setting 0.00 to 5.00 Hz
// RULE7 - Zero step keeps continuous up/down ramping
// RULE8 - Press under 2 s changes one step
// RULE9 - Press over 2 s ramps at selected rate
// RULE10 - Ramp slope is upper limit over ramp time
// RULE11 - Ramp set select: 0 set one, 1 set two
// RULE12 - Frequency and torque over thresholds, delay, release brake
// RULE13 - User enables frequency agree with brake release
// RULE14 - Brake release best used with frequency hold
// RULE15 - Hold mode 3 press sets run freq plus step
`timescale 1ns/1ps
`default_nettype none
module drive_io
	import drive_io_pkg::*;
#(
	parameter int unsigned TENTH_CYCLES = TENTH_S_CYCLES,
	parameter int unsigned HUNDREDTH_CYCLES = HUNDREDTH_S_CYCLES
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic [N_IN-1:0] input_terminals,
	input wire in_sel_t in_sel,
	input wire relay_sel_t relay_sel,
	input wire timer_cfg_s timer_cfg,
	input wire updown_cfg_s ud_cfg,
	input wire brake_cfg_s brake_cfg,
	input wire drive_state_s drive_state,
	output logic [N_RELAY-1:0] relay_out,
	output logic timer_out,
	output logic [15:0] freq_ref,
	output logic brake_release
);

	logic [N_IN-1:0] term_meta_q, term_sync_q;
	logic timer_in, timer_en, up_in, down_in;
	logic [15:0] on_lim, off_lim, step, brake_lim;
	logic [7:0] tq_lim;

	// Settings beyond their range saturate at the ceiling
	assign on_lim = (timer_cfg.on_delay > TIMER_DELAY_MAX) ? TIMER_DELAY_MAX : timer_cfg.on_delay;
	assign off_lim = (timer_cfg.off_delay > TIMER_DELAY_MAX) ? TIMER_DELAY_MAX
		: timer_cfg.off_delay;
	assign step = (ud_cfg.step_width > STEP_WIDTH_MAX) ? STEP_WIDTH_MAX : ud_cfg.step_width; // RULE6
	assign tq_lim = (brake_cfg.torque_level > TORQUE_LEVEL_MAX) ? TORQUE_LEVEL_MAX
		: brake_cfg.torque_level;
	assign brake_lim = (brake_cfg.delay > BRAKE_DELAY_MAX) ? BRAKE_DELAY_MAX : brake_cfg.delay;

	// Terminals come from switches, two stages before any use
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			term_meta_q <= '0;
			term_sync_q <= '0;
		end
		else
		begin
			term_meta_q <= input_terminals;
			term_sync_q <= term_meta_q;
		end
	end

	always_comb
	begin
		logic in_has, out_has;
		in_has = 1'b0;
		out_has = 1'b0;
		timer_in = 1'b0;
		up_in = 1'b0;
		down_in = 1'b0;
		for (int i = 0; i < N_IN; i++)
		begin
			if (in_sel[i] == SEL_TIMER_IN)
			begin
				in_has = 1'b1;
				timer_in = timer_in | term_sync_q[i];
			end
			up_in = up_in | (term_sync_q[i] && in_sel[i] == SEL_UP); // RULE5
			down_in = down_in | (term_sync_q[i] && in_sel[i] == SEL_DOWN); // RULE5
		end
		for (int j = 0; j < N_RELAY; j++)
		begin
			out_has = out_has | (relay_sel[j] == SEL_TIMER_OUT);
		end
		timer_en = in_has && out_has; // RULE1
	end

	// Timer relay
	logic tout_q, tout_d, on_done, off_done;
	logic [N_RELAY-1:0] relay_q, relay_d;

	hold_timer #(.TICK_CYCLES(TENTH_CYCLES)) on_timer (
		.clk(clk),
		.reset(reset),
		.run(timer_en && timer_in && !tout_q), // RULE4
		.limit(on_lim),
		.done(on_done)
	);

	hold_timer #(.TICK_CYCLES(TENTH_CYCLES)) off_timer (
		.clk(clk),
		.reset(reset),
		.run(timer_en && !timer_in && tout_q), // RULE4
		.limit(off_lim),
		.done(off_done)
	);

	always_comb
	begin
		tout_d = tout_q;
		if (!timer_en)
		begin
			tout_d = 1'b0; // RULE1
		end
		else if (on_done)
		begin
			tout_d = 1'b1; // RULE2
		end
		else if (off_done)
		begin
			tout_d = 1'b0; // RULE3
		end
		for (int j = 0; j < N_RELAY; j++)
		begin
			relay_d[j] = tout_d && (relay_sel[j] == SEL_TIMER_OUT);
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tout_q <= 1'b0;
			relay_q <= '0;
		end
		else
		begin
			tout_q <= tout_d;
			relay_q <= relay_d;
		end
	end

	assign timer_out = tout_q;
	assign relay_out = relay_q;

	// Up/down frequency reference
	logic press, dir_up, long_done;
	logic press_q, dir_q, long_q, taken_q;
	logic press_d, dir_d, long_d, taken_d;
	logic [15:0] freq_q, freq_d, ramp_time;
	logic [31:0] acc_q, acc_d;
	logic [$clog2(TENTH_CYCLES)-1:0] tick_q, tick_d;
	logic tick, ramping;

	// Both keys together count as no command
	assign press = up_in ^ down_in;
	assign dir_up = up_in;

	hold_timer #(.TICK_CYCLES(TENTH_CYCLES)) long_timer (
		.clk(clk),
		.reset(reset),
		.run(press && press_q && dir_q == dir_up),
		.limit(LONG_PRESS_TENTHS),
		.done(long_done)
	);

	always_comb
	begin
		if (ud_cfg.ramp_set) // RULE11
		begin
			ramp_time = dir_q ? ud_cfg.accel2 : ud_cfg.decel2;
		end
		else
		begin
			ramp_time = dir_q ? ud_cfg.accel1 : ud_cfg.decel1;
		end
	end

	assign tick = (tick_q == ($clog2(TENTH_CYCLES))'(TENTH_CYCLES - 1));
	assign ramping = press_q && press && dir_q == dir_up
		&& (step == 16'h0000 || long_done); // RULE7 RULE9

	always_comb
	begin
		logic [16:0] sum;
		press_d = press;
		dir_d = press ? dir_up : dir_q;
		long_d = press_q && press && (long_q || long_done);
		taken_d = press && press_q && taken_q;
		freq_d = freq_q;
		acc_d = '0;
		tick_d = tick ? '0 : tick_q + 1'b1;
		sum = '0;
		if (press && !press_q && ud_cfg.hold_mode == HOLD_REFRESH && drive_state.running
			&& drive_state.out_freq < freq_q)
		begin
			sum = {1'b0, drive_state.run_freq} + {1'b0, step}; // RULE15
			freq_d = sum[15:0];
			taken_d = 1'b1;
		end
		else if (!press && press_q && step != 16'h0000 && !long_q && !taken_q)
		begin
			// Short press applies one step on release
			sum = dir_q ? {1'b0, freq_q} + {1'b0, step} : {1'b0, freq_q} - {1'b0, step}; // RULE8
			if (!dir_q && step > freq_q)
			begin
				sum = '0;
			end
			freq_d = sum[15:0];
		end
		else if (ramping)
		begin
			// Error-free slope: add the limit per tick, spend ramp time per LSB
			acc_d = tick ? acc_q + {16'h0000, ud_cfg.upper_limit} : acc_q; // RULE10
			if (ramp_time == 16'h0000)
			begin
				freq_d = dir_q ? ud_cfg.upper_limit : 16'h0000;
			end
			else if (!tick && acc_q >= {16'h0000, ramp_time})
			begin
				acc_d = acc_q - {16'h0000, ramp_time}; // RULE9
				if (dir_q && freq_q < ud_cfg.upper_limit)
				begin
					freq_d = freq_q + 16'h0001;
				end
				else if (!dir_q && freq_q != 16'h0000)
				begin
					freq_d = freq_q - 16'h0001;
				end
			end
		end
		if (sum[16] || freq_d > ud_cfg.upper_limit)
		begin
			freq_d = ud_cfg.upper_limit;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			press_q <= 1'b0;
			dir_q <= 1'b0;
			long_q <= 1'b0;
			taken_q <= 1'b0;
			freq_q <= '0;
			acc_q <= '0;
			tick_q <= '0;
		end
		else
		begin
			press_q <= press_d;
			dir_q <= dir_d;
			long_q <= long_d;
			taken_q <= taken_d;
			freq_q <= freq_d;
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign freq_ref = freq_q;

	// Brake release
	logic brake_cond, brake_done, brake_q, brake_d;

	// Frequency agree setup and hold use stay with the user
	assign brake_cond = drive_state.running && drive_state.out_freq > brake_cfg.freq_level
		&& drive_state.torque > tq_lim; // RULE12

	hold_timer #(.TICK_CYCLES(HUNDREDTH_CYCLES)) brake_timer (
		.clk(clk),
		.reset(reset),
		.run(brake_cond),
		.limit(brake_lim),
		.done(brake_done)
	);

	always_comb
	begin
		// Brake closes on the next clock after the condition drops, with no delay
		brake_d = brake_done; // RULE12
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			brake_q <= 1'b0;
		end
		else
		begin
			brake_q <= brake_d;
		end
	end

	assign brake_release = brake_q;

endmodule : drive_io
`default_nettype wire

// >>> dv/drive_io_assertions.sv
// Port assertions for the drive I/O block
`timescale 1ns/1ps
`default_nettype none
module drive_io_assertions
	import drive_io_pkg::*;
#(
	parameter int unsigned TENTH_CYCLES = TENTH_S_CYCLES,
	parameter int unsigned HUNDREDTH_CYCLES = HUNDREDTH_S_CYCLES
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic [N_IN-1:0] input_terminals,
	input wire in_sel_t in_sel,
	input wire relay_sel_t relay_sel,
	input wire timer_cfg_s timer_cfg,
	input wire updown_cfg_s ud_cfg,
	input wire brake_cfg_s brake_cfg,
	input wire drive_state_s drive_state,
	input wire logic [N_RELAY-1:0] relay_out,
	input wire logic timer_out,
	input wire logic [15:0] freq_ref,
	input wire logic brake_release
);
	logic tin, udin, cond, en;
	logic [31:0] hi_q, hi_d, lo_q, lo_d, br_q, br_d;
	// Timer counts use raw pins, so sync latency only adds margin
	always_comb
	begin
		tin = 1'h0;
		udin = 1'h0;
		en = 1'h0;
		for (int i = 0; i < N_IN; i++)
		begin
			tin |= input_terminals[i] && in_sel[i] == SEL_TIMER_IN;
			en |= in_sel[i] == SEL_TIMER_IN;
			udin |= input_terminals[i] && (in_sel[i] == SEL_UP || in_sel[i] == SEL_DOWN);
		end
		en &= relay_sel[0] == SEL_TIMER_OUT || relay_sel[1] == SEL_TIMER_OUT
			|| relay_sel[2] == SEL_TIMER_OUT;
		cond = drive_state.running && drive_state.out_freq > brake_cfg.freq_level
			&& drive_state.torque > brake_cfg.torque_level;
		hi_d = tin ? hi_q + 32'h1 : 32'h0;
		lo_d = tin ? 32'h0 : lo_q + 32'h1;
		br_d = cond ? br_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			hi_q <= 32'h0;
			lo_q <= 32'h0;
			br_q <= 32'h0;
		end
		else
		begin
			hi_q <= hi_d;
			lo_q <= lo_d;
			br_q <= br_d;
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_ud_quiet;
		!udin [*8];
	endsequence
	sequence s_cond_gone;
		!cond ##1 !cond;
	endsequence
	chk_relay_select: assert property ((relay_sel[0] != SEL_TIMER_OUT) [*2] |-> !relay_out[0])
		else $error("relay on without timer code");
	chk_timer_enable: assert property (!en [*2] |-> !timer_out)
		else $error("timer on while disabled");
	chk_on_delay: assert property ($rose(timer_out) |-> hi_q >= timer_cfg.on_delay * TENTH_CYCLES)
		else $error("timer rose early");
	chk_off_delay: assert property ($fell(timer_out) && $past(en) |-> lo_q >= timer_cfg.off_delay * TENTH_CYCLES)
		else $error("timer fell early");
	chk_brake_delay: assert property ($rose(brake_release) |-> br_q >= brake_cfg.delay * HUNDREDTH_CYCLES)
		else $error("brake released early");
	chk_brake_drop: assert property (s_cond_gone |-> !brake_release)
		else $error("brake held without condition");
	chk_brake_cause: assert property (brake_release |-> $past(cond))
		else $error("brake released without condition");
	chk_ref_limit: assert property (ud_cfg.hold_mode != HOLD_REFRESH |-> freq_ref <= ud_cfg.upper_limit)
		else $error("reference above upper limit");
	chk_ref_quiet: assert property (s_ud_quiet |-> $stable(freq_ref))
		else $error("reference moved without a press");
endmodule : drive_io_assertions
bind drive_io drive_io_assertions #(.TENTH_CYCLES(TENTH_CYCLES), .HUNDREDTH_CYCLES(HUNDREDTH_CYCLES))
	i_drive_io_assertions (.clk(clk), .reset(reset), .input_terminals(input_terminals),
	.in_sel(in_sel), .relay_sel(relay_sel), .timer_cfg(timer_cfg), .ud_cfg(ud_cfg),
	.brake_cfg(brake_cfg), .drive_state(drive_state), .relay_out(relay_out),
	.timer_out(timer_out), .freq_ref(freq_ref), .brake_release(brake_release));
`default_nettype wire

// >>> dv/terminal_switches.sv
// Switch contacts wired to the input terminals
`timescale 1ns/1ps
`default_nettype none
module terminal_switches
	import drive_io_pkg::*;
(
	input wire logic [N_IN-1:0] closed,
	output logic [N_IN-1:0] input_terminals
);
	// Pull-downs: an open contact reads low, never the last level
	assign input_terminals = closed;
endmodule : terminal_switches
`default_nettype wire

// >>> dv/drive_io_test.sv
// Self-checking bench for the drive I/O block
`timescale 1ns/1ps
`default_nettype none
module drive_io_test
	import drive_io_pkg::*;
;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [N_IN-1:0] closed = '0;
	logic [N_IN-1:0] input_terminals;
	in_sel_t in_sel = '0;
	relay_sel_t relay_sel = '0;
	timer_cfg_s timer_cfg = '0;
	updown_cfg_s ud_cfg = '0;
	brake_cfg_s brake_cfg = '0;
	drive_state_s drive_state = '0;
	logic [N_RELAY-1:0] relay_out;
	logic timer_out, brake_release;
	logic [15:0] freq_ref, base;
	int n_errors = 0, num_checks = 0, cycles = 0;
	always #2.5 clk = ~clk;
	terminal_switches i_terminal_switches (.closed(closed), .input_terminals(input_terminals));
	// Short ticks keep the run brief: 0.1 s is 10 cycles, 0.01 s is 4
	drive_io #(.TENTH_CYCLES(10), .HUNDREDTH_CYCLES(4)) i_drive_io (.clk(clk), .reset(reset),
		.input_terminals(input_terminals), .in_sel(in_sel), .relay_sel(relay_sel),
		.timer_cfg(timer_cfg), .ud_cfg(ud_cfg), .brake_cfg(brake_cfg),
		.drive_state(drive_state), .relay_out(relay_out), .timer_out(timer_out),
		.freq_ref(freq_ref), .brake_release(brake_release));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic level(input int t, input logic v, input int n);
		@(negedge clk);
		closed[t] = v;
		repeat (n) @(negedge clk);
	endtask : level
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			conclude();
		end
	end
	initial
	begin
		in_sel[0] = SEL_TIMER_IN;
		in_sel[1] = SEL_UP;
		in_sel[2] = SEL_DOWN;
		relay_sel[0] = SEL_TIMER_OUT;
		timer_cfg = {16'h0003, 16'h0002};
		// Slopes stay under one step per cycle, the most a ramp can move with short ticks
		ud_cfg = {16'h0064, 1'h0, 16'h03E8, 16'h03E8, 16'h07D0, 16'h04E2, 16'h1388, 2'h0};
		brake_cfg = {16'h03E8, 8'h32, 16'h0005};
		repeat (6) @(negedge clk);
		reset = 1'h0;
		level(0, 1'h1, 15);
		level(0, 1'h0, 10);
		check(timer_out, 1'h0);
		level(0, 1'h1, 45);
		check(timer_out, 1'h1);
		check(relay_out, 3'h1);
		level(0, 1'h0, 10);
		level(0, 1'h1, 5);
		check(timer_out, 1'h1);
		level(0, 1'h0, 40);
		check(timer_out, 1'h0);
		level(0, 1'h1, 45);
		relay_sel[0] = 8'h00;
		repeat (5) @(negedge clk);
		check({timer_out, relay_out}, 4'h0);
		relay_sel[0] = SEL_TIMER_OUT;
		level(0, 1'h0, 40);
		$display("timer test done");
		level(1, 1'h1, 50);
		level(1, 1'h0, 10);
		check(freq_ref, 16'h0064);
		level(2, 1'h1, 50);
		level(2, 1'h0, 10);
		check(freq_ref, 16'h0000);
		level(1, 1'h1, 400);
		level(1, 1'h0, 10);
		check(freq_ref >= 16'h0055 && freq_ref <= 16'h0073, 1'h1);
		base = freq_ref;
		ud_cfg.ramp_set = 1'h1;
		level(1, 1'h1, 400);
		level(1, 1'h0, 10);
		check(freq_ref - base >= 16'h0028 && freq_ref - base <= 16'h003C, 1'h1);
		base = freq_ref;
		level(2, 1'h1, 400);
		level(2, 1'h0, 10);
		check(base - freq_ref >= 16'h0046 && base - freq_ref <= 16'h005A, 1'h1);
		ud_cfg.step_width = 16'h0000;
		base = freq_ref;
		level(1, 1'h1, 50);
		level(1, 1'h0, 10);
		check(freq_ref - base >= 16'h0005 && freq_ref - base <= 16'h0014, 1'h1);
		ud_cfg.step_width = 16'h0064;
		ud_cfg.hold_mode = HOLD_REFRESH;
		drive_state.running = 1'h1;
		drive_state.run_freq = 16'h02BC;
		level(1, 1'h1, 20);
		level(1, 1'h0, 10);
		check(freq_ref, 16'h0320);
		ud_cfg.hold_mode = 2'h0;
		$display("up down test done");
		drive_state.out_freq = 16'h07D0;
		drive_state.torque = 8'h64;
		repeat (15) @(negedge clk);
		check(brake_release, 1'h0);
		repeat (10) @(negedge clk);
		check(brake_release, 1'h1);
		drive_state.torque = 8'h28;
		repeat (3) @(negedge clk);
		check(brake_release, 1'h0);
		$display("brake test done");
		conclude();
	end
endmodule : drive_io_test
`default_nettype wire
